// ==== design/wwd_pkg.sv ====
// Purpose: Shared constants and types of the window watchdog.
// Assumes: 100 MHz system clock, one timebase tick per microsecond.
// Notes:   All window and delay figures are typical values in microseconds.
package wwd_pkg;

	// Clock and timebase
	localparam int CLK_PERIOD_NS = 10;
	localparam int TICK_NS       = 1000;
	localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;

	// Timing pin encodings as sensed at power-up
	localparam logic [1:0] PIN_OPEN   = 2'h0;
	localparam logic [1:0] PIN_PULLUP = 2'h1;
	localparam logic [1:0] PIN_CAP    = 2'h2;

	// Ratio select settings {ratio_select_0, ratio_select_1}
	localparam logic [1:0] RATIO_1_8  = 2'h0;
	localparam logic [1:0] RATIO_3_4  = 2'h1;
	localparam logic [1:0] RATIO_OFF  = 2'h2;
	localparam logic [1:0] RATIO_1_2  = 2'h3;

	// Reset delay, microseconds
	localparam logic [31:0] RST_OPEN_US    = 32'h0003_0d40; // 200 ms
	localparam logic [31:0] RST_PULLUP_US  = 32'h0000_2710; // 10 ms
	localparam logic [31:0] RST_CAP_OFS_US = 32'h0000_017d; // 381 us
	localparam logic [31:0] RST_CAP_MUL    = 32'h0000_0142; // 3.22 us/pF, x100
	localparam logic [31:0] RST_CAP_DIV    = 32'h0000_0064;

	// Upper and lower window bounds, microseconds
	localparam logic [31:0] UP_OPEN_00_US  = 32'h0000_d6d8; // 55.0 ms
	localparam logic [31:0] LO_OPEN_00_US  = 32'h0000_57e4; // 22.5 ms
	localparam logic [31:0] UP_OPEN_01_US  = 32'h0000_6b6c; // 27.5 ms
	localparam logic [31:0] LO_OPEN_01_US  = 32'h0000_073a; // 1.85 ms
	localparam logic [31:0] UP_OPEN_11_US  = 32'h0018_6a00; // 1600 ms
	localparam logic [31:0] LO_OPEN_11_US  = 32'h000c_3500; // 800 ms
	localparam logic [31:0] UP_PU_00_US    = 32'h0001_a9c8; // 109.0 ms
	localparam logic [31:0] UP_PU_01_US    = 32'h0002_f9b8; // 195.0 ms
	localparam logic [31:0] UP_PU_11_US    = 32'h0000_2af8; // 11.0 ms
	localparam logic [31:0] LO_PU_US       = 32'h0000_2328; // 9.0 ms
	localparam logic [31:0] LO_PU_11_US    = 32'h0000_073a; // 1.85 ms
	localparam logic [31:0] UP_CAP_OFS_US  = 32'h0000_d6d8; // 55 ms
	localparam logic [31:0] UP_CAP_MUL     = 32'h0000_0306; // 77.4 us/pF, x10
	localparam logic [31:0] UP_CAP_DIV     = 32'h0000_000a;

	// Register byte offsets
	localparam logic [7:0] REG_RST_CAP   = 8'h00;
	localparam logic [7:0] REG_WIN_CAP   = 8'h04;
	localparam logic [7:0] REG_STATUS    = 8'h08;
	localparam logic [7:0] REG_FAULT_CNT = 8'h0c;
	localparam logic [7:0] REG_ELAPSED   = 8'h10;

	// Reset values
	localparam logic [19:0] CAP_PF_RST = 20'h0_2710; // 10 nF

	// Bounds carried from the bounds unit to the checker
	typedef struct packed {
		logic [31:0] upper_us;
		logic [31:0] lower_us;
		logic [31:0] delay_us;
	} wwd_bounds_type;

	typedef enum logic [2:0] {
		ST_OFF, ST_INIT, ST_FIRST, ST_WINDOW, ST_FAULT, ST_DISABLED
	} wwd_state_type;

endpackage : wwd_pkg

// ==== design/wwd_tick.sv ====
// Purpose: Microsecond timebase pulse.
// Assumes: Synchronous active-high reset.
// Notes:   One-cycle tick every CYCLES clocks.
module wwd_tick #(
	parameter int CYCLES = wwd_pkg::TICK_CYCLES
) (
	input  wire logic sys_clk_i,
	input  wire logic srst_i,
	output logic      tick_o
);

	// The wrap compare is 16 bits wide
	if (CYCLES < 2 || CYCLES > 65536) begin : g_chk
		$error("wwd_tick: CYCLES must be 2 to 65536");
	end

	logic [15:0] cnt;
	logic [15:0] next_cnt;
	logic        next_tick;

	// Wrap counter and pulse
	always_comb begin
		next_tick = (cnt == 16'(CYCLES - 1));
		next_cnt  = next_tick ? 16'h0000 : cnt + 16'h0001;
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			cnt    <= 16'h0000;
			tick_o <= 1'b0;
		end else begin
			cnt    <= next_cnt;
			tick_o <= next_tick;
		end
	end

endmodule : wwd_tick

// ==== design/wwd_bounds.sv ====
// Purpose: Window bounds and reset delay from pin modes, ratio and capacitors.
// Assumes: Capacitances given in picofarads.
// Notes:   Result registered; follows its inputs one cycle later.
module wwd_bounds (
	input  wire logic               sys_clk_i,
	input  wire logic               srst_i,
	input  wire logic [1:0]         win_mode_i,
	input  wire logic [1:0]         rst_mode_i,
	input  wire logic [1:0]         ratio_i,
	input  wire logic [19:0]        win_cap_pf_i,
	input  wire logic [19:0]        rst_cap_pf_i,
	output wwd_pkg::wwd_bounds_type bounds_o
);

	wwd_pkg::wwd_bounds_type next_bounds;
	logic [31:0]             cap_up;

	// Factory tables or capacitor formulas
	always_comb begin
		cap_up = (wwd_pkg::UP_CAP_MUL * 32'(win_cap_pf_i)) / wwd_pkg::UP_CAP_DIV
			+ wwd_pkg::UP_CAP_OFS_US; // see [R11]
		next_bounds = '0;
		unique case (rst_mode_i)  // see [R5] [R6]
			wwd_pkg::PIN_OPEN:   next_bounds.delay_us = wwd_pkg::RST_OPEN_US;
			wwd_pkg::PIN_PULLUP: next_bounds.delay_us = wwd_pkg::RST_PULLUP_US;
			default: next_bounds.delay_us = (wwd_pkg::RST_CAP_MUL * 32'(rst_cap_pf_i))
				/ wwd_pkg::RST_CAP_DIV + wwd_pkg::RST_CAP_OFS_US;
		endcase
		if (win_mode_i == wwd_pkg::PIN_OPEN) begin  // see [R8] [R9]
			unique case (ratio_i)
				wwd_pkg::RATIO_1_8: next_bounds.upper_us = wwd_pkg::UP_OPEN_00_US;
				wwd_pkg::RATIO_3_4: next_bounds.upper_us = wwd_pkg::UP_OPEN_01_US;
				default:            next_bounds.upper_us = wwd_pkg::UP_OPEN_11_US;
			endcase
			unique case (ratio_i)
				wwd_pkg::RATIO_1_8: next_bounds.lower_us = wwd_pkg::LO_OPEN_00_US;
				wwd_pkg::RATIO_3_4: next_bounds.lower_us = wwd_pkg::LO_OPEN_01_US;
				default:            next_bounds.lower_us = wwd_pkg::LO_OPEN_11_US;
			endcase
		end else if (win_mode_i == wwd_pkg::PIN_PULLUP) begin  // see [R10]
			unique case (ratio_i)
				wwd_pkg::RATIO_1_8: next_bounds.upper_us = wwd_pkg::UP_PU_00_US;
				wwd_pkg::RATIO_3_4: next_bounds.upper_us = wwd_pkg::UP_PU_01_US;
				default:            next_bounds.upper_us = wwd_pkg::UP_PU_11_US;
			endcase
			next_bounds.lower_us = (ratio_i == wwd_pkg::RATIO_1_2) ?
				wwd_pkg::LO_PU_11_US : wwd_pkg::LO_PU_US;
		end else begin
			next_bounds.upper_us = cap_up;
			unique case (ratio_i)  // see [R12] [R13]
				wwd_pkg::RATIO_1_8: next_bounds.lower_us = cap_up >> 3;
				wwd_pkg::RATIO_3_4: next_bounds.lower_us = cap_up - (cap_up >> 2);
				default:            next_bounds.lower_us = cap_up >> 1;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			bounds_o <= '0;
		end else begin
			bounds_o <= next_bounds;
		end
	end

endmodule : wwd_bounds

// ==== design/wwd_top.sv ====
// Purpose: Window watchdog checking falling-edge spacing on the kick input.
// Assumes: All pins synchronous to sys_clk_i; APB slave for configuration.
// Notes:   Intervals counted in timebase ticks of TICK_CYCLES clocks.
//
// Design decisions made here: the address map and the APB register port.

// Summary of operation
// [R1] Enabled and powered: output follows kick timing only
// [R2] Power-up: wait one reset delay before checking
// [R3] First edge later than upper bound faults
// [R4] Later edges outside lower/upper window fault
// [R5] Delay pin open 200 ms, pulled up 10 ms
// [R6] Capacitor delay: 3.22 us/pF plus 381 us
// [R7] Capacitor discharged in fault, recharged before release; here discharge lasts the whole fault and ends in the cycle of release
// [R8] Open or pulled-up window pin: factory timeouts
// [R9] Open pin uppers 55.0, 27.5, 1600 ms
// [R10] Pulled-up uppers 109.0, 195.0 ms, lower 9.0
// [R11] Capacitor upper: 77.4 us/pF plus 55 ms
// [R12] Capacitor lower bound is ratio of upper
// [R13] Ratios 1:8, 3:4, 1:2; setting 10 disables
// [R14] Kick ignored while fault output asserted
// [R15] Only falling kick edges are service events
// [R16] Disabled: output released, kick ignored
// [R17] Output active low; times counted in ticks
// [R18] Timing pin modes sampled once after power-up
module wwd_top #(
	parameter int TICK_CYCLES = wwd_pkg::TICK_CYCLES
) (
	input  wire logic        sys_clk_i,
	input  wire logic        srst_i,
	input  wire logic        supply_valid_i,
	input  wire logic        kick_input_i,
	input  wire logic        ratio_select_0_i,
	input  wire logic        ratio_select_1_i,
	input  wire logic [1:0]  window_timing_pin_i,
	input  wire logic [1:0]  reset_delay_pin_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic [31:0]      prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	output logic             fault_reset_output_n_o,
	output logic             cap_discharge_o
);

	if (TICK_CYCLES < 2) begin : g_chk
		$error("wwd_top: TICK_CYCLES must be at least 2");
	end

	wwd_pkg::wwd_state_type  state;
	wwd_pkg::wwd_state_type  next_state;
	wwd_pkg::wwd_bounds_type bounds;
	logic [31:0]             elapsed;
	logic [31:0]             next_elapsed;
	logic                    kick_prev;
	logic                    kick_fall;
	logic                    tick;
	logic [1:0]              ratio_live;
	logic [1:0]              ratio_lat;
	logic [1:0]              next_ratio_lat;
	logic [1:0]              win_mode;
	logic [1:0]              next_win_mode;
	logic [1:0]              rst_mode;
	logic [1:0]              next_rst_mode;
	logic [15:0]             fault_cnt;
	logic [15:0]             next_fault_cnt;
	logic                    next_out_n;
	logic                    next_discharge;
	logic                    time_up;
	logic [19:0]             rst_cap_pf;
	logic [19:0]             win_cap_pf;
	logic [19:0]             next_rst_cap_pf;
	logic [19:0]             next_win_cap_pf;
	logic [31:0]             next_prdata;
	logic                    next_pready;
	logic                    next_pslverr;
	logic                    wr_go;

	wwd_tick #(
		.CYCLES (TICK_CYCLES)
	) u_tick (
		.sys_clk_i (sys_clk_i),
		.srst_i    (srst_i),
		.tick_o    (tick)
	);

	wwd_bounds u_bounds (
		.sys_clk_i    (sys_clk_i),
		.srst_i       (srst_i),
		.win_mode_i   (win_mode),
		.rst_mode_i   (rst_mode),
		.ratio_i      (ratio_lat),
		.win_cap_pf_i (win_cap_pf),
		.rst_cap_pf_i (rst_cap_pf),
		.bounds_o     (bounds)
	);

	// Ratio select pins and edge detection
	assign ratio_live = {ratio_select_0_i, ratio_select_1_i};
	assign kick_fall  = kick_prev & ~kick_input_i;  // see [R15]

	// Watchdog state, timer and latched settings
	always_comb begin
		next_state     = state;
		next_elapsed   = tick ? elapsed + 32'h0000_0001 : elapsed;  // see [R17]
		next_ratio_lat = ratio_lat;
		next_win_mode  = win_mode;
		next_rst_mode  = rst_mode;
		next_fault_cnt = fault_cnt;
		time_up        = 1'b0;
		unique case (state)
			wwd_pkg::ST_OFF: begin
				next_elapsed = '0;
				if (supply_valid_i) begin
					next_win_mode  = window_timing_pin_i;  // see [R18]
					next_rst_mode  = reset_delay_pin_i;
					next_ratio_lat = ratio_live;
					next_state     = wwd_pkg::ST_INIT;
				end
			end
			wwd_pkg::ST_INIT: begin
				time_up = elapsed >= bounds.delay_us;
				if (time_up) begin  // see [R2]
					next_state   = wwd_pkg::ST_FIRST;
					next_elapsed = '0;
				end
			end
			wwd_pkg::ST_FIRST, wwd_pkg::ST_WINDOW: begin
				time_up = elapsed >= bounds.upper_us;
				if (kick_fall && state == wwd_pkg::ST_WINDOW
						&& elapsed < bounds.lower_us) begin  // see [R4]
					next_state = wwd_pkg::ST_FAULT;
				end else if (kick_fall && !time_up) begin  // see [R1] [R3]
					next_state   = wwd_pkg::ST_WINDOW;
					next_elapsed = '0;
				end else if (time_up) begin  // see [R3] [R4]
					next_state = wwd_pkg::ST_FAULT;
				end
				if (next_state == wwd_pkg::ST_FAULT) begin
					next_elapsed   = '0;
					next_ratio_lat = ratio_live;
					next_fault_cnt = fault_cnt + 16'h0001;
				end
			end
			wwd_pkg::ST_FAULT: begin
				time_up = elapsed >= bounds.delay_us;
				if (time_up) begin  // see [R14] [R7]
					next_state   = wwd_pkg::ST_FIRST;
					next_elapsed = '0;
				end
			end
			wwd_pkg::ST_DISABLED: begin
				next_elapsed = '0;
				next_state   = wwd_pkg::ST_FIRST;
			end
		endcase
		if (!supply_valid_i) begin
			next_state   = wwd_pkg::ST_OFF;
			next_elapsed = '0;
		end else if (ratio_live == wwd_pkg::RATIO_OFF && state != wwd_pkg::ST_OFF
				&& state != wwd_pkg::ST_INIT) begin  // see [R16]
			// A fault entry overridden by disable in the same cycle is neither latched nor counted
			next_state     = wwd_pkg::ST_DISABLED;
			next_elapsed   = '0;
			next_ratio_lat = ratio_lat;
			next_fault_cnt = fault_cnt;
		end
		next_out_n     = next_state != wwd_pkg::ST_FAULT;  // see [R17]
		next_discharge = next_state == wwd_pkg::ST_FAULT
			&& next_rst_mode == wwd_pkg::PIN_CAP;  // see [R7]
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			state                  <= wwd_pkg::ST_OFF;
			elapsed                <= '0;
			kick_prev              <= 1'b0;
			ratio_lat              <= wwd_pkg::RATIO_1_8;
			win_mode               <= wwd_pkg::PIN_OPEN;
			rst_mode               <= wwd_pkg::PIN_OPEN;
			fault_cnt              <= '0;
			fault_reset_output_n_o <= 1'b1;
			cap_discharge_o        <= 1'b0;
		end else begin
			state                  <= next_state;
			elapsed                <= next_elapsed;
			kick_prev              <= kick_input_i;
			ratio_lat              <= next_ratio_lat;
			win_mode               <= next_win_mode;
			rst_mode               <= next_rst_mode;
			fault_cnt              <= next_fault_cnt;
			fault_reset_output_n_o <= next_out_n;
			cap_discharge_o        <= next_discharge;
		end
	end

	// APB slave, answer in the second access cycle
	always_comb begin
		next_pready     = psel_i & penable_i & ~pready_o;
		wr_go           = psel_i & penable_i & pready_o & pwrite_i & ~pslverr_o;
		next_rst_cap_pf = rst_cap_pf;
		next_win_cap_pf = win_cap_pf;
		next_prdata     = '0;
		next_pslverr    = 1'b0;
		unique case (paddr_i)
			wwd_pkg::REG_RST_CAP:   next_prdata = {12'h000, rst_cap_pf};
			wwd_pkg::REG_WIN_CAP:   next_prdata = {12'h000, win_cap_pf};
			wwd_pkg::REG_STATUS:    next_prdata = {24'h00_0000,
				cap_discharge_o, ratio_lat, state == wwd_pkg::ST_DISABLED,
				state == wwd_pkg::ST_INIT, state == wwd_pkg::ST_FIRST,
				state == wwd_pkg::ST_WINDOW, state == wwd_pkg::ST_FAULT};
			wwd_pkg::REG_FAULT_CNT: next_prdata = {16'h0000, fault_cnt};
			wwd_pkg::REG_ELAPSED:   next_prdata = elapsed;
			default:                next_pslverr = next_pready;
		endcase
		if (pwrite_i && (paddr_i == wwd_pkg::REG_STATUS || paddr_i == wwd_pkg::REG_FAULT_CNT
				|| paddr_i == wwd_pkg::REG_ELAPSED)) begin
			next_pslverr = next_pready;
		end
		if (pwrite_i || !next_pready) begin
			next_prdata = '0;
		end
		if (wr_go && paddr_i == wwd_pkg::REG_RST_CAP) begin
			next_rst_cap_pf = pwdata_i[19:0];
		end
		if (wr_go && paddr_i == wwd_pkg::REG_WIN_CAP) begin
			next_win_cap_pf = pwdata_i[19:0];
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			rst_cap_pf <= wwd_pkg::CAP_PF_RST;
			win_cap_pf <= wwd_pkg::CAP_PF_RST;
			prdata_o   <= '0;
			pready_o   <= 1'b0;
			pslverr_o  <= 1'b0;
		end else begin
			rst_cap_pf <= next_rst_cap_pf;
			win_cap_pf <= next_win_cap_pf;
			prdata_o   <= next_prdata;
			pready_o   <= next_pready;
			pslverr_o  <= next_pslverr;
		end
	end

	// Checks on the watchdog behaviour
	sequence fault_entry_s;
		state != wwd_pkg::ST_FAULT ##1 state == wwd_pkg::ST_FAULT;
	endsequence

	sequence fault_hold_s;
		(state == wwd_pkg::ST_FAULT && !fault_reset_output_n_o) [*8];
	endsequence

	fault_held_a: assert property (@(posedge sys_clk_i) // see [R14]
		disable iff (srst_i || !supply_valid_i || ratio_live == wwd_pkg::RATIO_OFF)
		fault_entry_s ##0 (supply_valid_i && ratio_live != wwd_pkg::RATIO_OFF) [*8]
		|=> fault_hold_s)
		else $error("fault released too early");

	out_low_fault_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // see [R17]
		fault_reset_output_n_o == (state != wwd_pkg::ST_FAULT))
		else $error("output level does not match fault state");

	early_kick_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // see [R4]
		state == wwd_pkg::ST_WINDOW && kick_fall && elapsed < bounds.lower_us
		&& supply_valid_i && ratio_live != wwd_pkg::RATIO_OFF
		|=> state == wwd_pkg::ST_FAULT && elapsed == 32'h0000_0000)
		else $error("early kick did not fault");

	late_kick_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // see [R3]
		state == wwd_pkg::ST_FIRST && !kick_fall && elapsed >= bounds.upper_us
		&& supply_valid_i && ratio_live != wwd_pkg::RATIO_OFF
		|=> !fault_reset_output_n_o)
		else $error("missing kick did not fault");

	good_kick_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // see [R1]
		state == wwd_pkg::ST_WINDOW && kick_fall && elapsed >= bounds.lower_us
		&& elapsed < bounds.upper_us && supply_valid_i
		&& ratio_live != wwd_pkg::RATIO_OFF
		|=> state == wwd_pkg::ST_WINDOW && elapsed == 32'h0000_0000 && fault_reset_output_n_o)
		else $error("kick inside window not accepted");

	disabled_high_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // see [R16]
		supply_valid_i && ratio_live == wwd_pkg::RATIO_OFF && $past(supply_valid_i)
		&& state != wwd_pkg::ST_OFF && state != wwd_pkg::ST_INIT
		|=> fault_reset_output_n_o ##1 fault_reset_output_n_o)
		else $error("disabled watchdog drove its output");

	powerup_wait_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // see [R2]
		state == wwd_pkg::ST_INIT && elapsed < bounds.delay_us && supply_valid_i
		|=> state == wwd_pkg::ST_INIT && fault_reset_output_n_o)
		else $error("checking began before the power-up delay");

	supply_off_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // see [R18]
		$fell(supply_valid_i) |-> ##1 state == wwd_pkg::ST_OFF ##1 fault_reset_output_n_o)
		else $error("supply loss did not restart the watchdog");

	discharge_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // see [R7]
		cap_discharge_o |-> !fault_reset_output_n_o && rst_mode == wwd_pkg::PIN_CAP)
		else $error("capacitor discharged outside a fault");

endmodule : wwd_top

// ==== tb/wwd_kick_model.sv ====
// Purpose: Supervised processor model that services the watchdog kick input.
// Assumes: Kick idles high; only the falling edge is a service event.
// Notes:   The bench chooses each gap, so edges can be early, on time or late.
module wwd_kick_model (
	input  wire logic sys_clk_i,
	output logic      kick_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// Idle level before any service
	initial begin
		kick_o = 1'b1;
	end

	// Falling edge after gap cycles, low for low_len cycles, then back high
	task automatic kick(input int gap, input int low_len);
		repeat (gap) @(posedge sys_clk_i);
		kick_o <= 1'b0;
		repeat (low_len) @(posedge sys_clk_i);
		kick_o <= 1'b1;
	endtask : kick

endmodule : wwd_kick_model

// ==== tb/window_watchdog_timer_tb_top.sv ====
// Purpose: Self-checking bench of the window watchdog through APB and the kick pin.
// Assumes: Timebase shortened to 2 clocks a tick; pull-up window pin, capacitor delay pin.
// Notes:   Waits are derived from the package bounds with a margin of some ticks.
module window_watchdog_timer_tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int TK   = 2;
	localparam int UPR  = wwd_pkg::UP_PU_11_US;
	localparam int LWR  = wwd_pkg::LO_PU_11_US;
	localparam int MID  = (LWR + UPR) / 2;
	localparam int D0   = wwd_pkg::RST_CAP_OFS_US;
	localparam int D100 = (wwd_pkg::RST_CAP_MUL * 100) / wwd_pkg::RST_CAP_DIV + D0;

	logic        sys_clk;
	logic        srst;
	logic        supply_ok;
	logic        kick;
	logic        sel0;
	logic        sel1;
	logic [1:0]  win_pin;
	logic [1:0]  dly_pin;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        fault_n;
	logic        cap_dis;
	int          errors;
	int          checked;

	// Clock generation
	initial begin
		sys_clk = 1'b0;
	end
	always #5 sys_clk = ~sys_clk;

	// Design and processor model
	wwd_top #(.TICK_CYCLES(TK)) i_dut (
		.sys_clk_i             (sys_clk),
		.srst_i                (srst),
		.supply_valid_i        (supply_ok),
		.kick_input_i          (kick),
		.ratio_select_0_i      (sel0),
		.ratio_select_1_i      (sel1),
		.window_timing_pin_i   (win_pin),
		.reset_delay_pin_i     (dly_pin),
		.psel_i                (psel),
		.penable_i             (penable),
		.pwrite_i              (pwrite),
		.paddr_i               (paddr),
		.pwdata_i              (pwdata),
		.prdata_o              (prdata),
		.pready_o              (pready),
		.pslverr_o             (pslverr),
		.fault_reset_output_n_o(fault_n),
		.cap_discharge_o       (cap_dis)
	);

	wwd_kick_model i_kick (
		.sys_clk_i(sys_clk),
		.kick_o   (kick)
	);

	// Verdict and end of run
	task automatic final_report();
		if (errors == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : final_report

	// Compare and count
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	// One APB transfer; read data compared under a mask
	task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
			input logic [31:0] exp, input logic [31:0] mask, input logic exp_err,
			input string name);
		int          n;
		logic [31:0] rd;
		logic        er;
		n = 0;
		@(posedge sys_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= addr;
		pwdata  <= wdata;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		chk({name, "_wait"}, 32'h2, n);
		chk({name, "_err"}, exp_err, er);
		if (!wr && !exp_err) begin
			chk(name, exp & mask, rd & mask);
		end
	endtask : apb

	// Hang guard
	initial begin
		repeat (90000) @(posedge sys_clk);
		errors++;
		final_report();
	end

	// Main sequence
	initial begin
		errors = 0;
		checked = 0;
		srst = 1'b1;
		supply_ok = 1'b0;
		sel0 = 1'b1;
		sel1 = 1'b1;
		win_pin = wwd_pkg::PIN_PULLUP;
		dly_pin = wwd_pkg::PIN_CAP;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (10) @(posedge sys_clk);
		srst <= 1'b0;
		@(posedge sys_clk);
		chk("out_unpowered", 32'h1, fault_n);
		apb(1'b0, wwd_pkg::REG_RST_CAP, 32'h0, 32'h2710, '1, 1'b0, "rst_cap");
		apb(1'b0, wwd_pkg::REG_WIN_CAP, 32'h0, 32'h2710, '1, 1'b0, "win_cap");
		apb(1'b1, wwd_pkg::REG_WIN_CAP, 32'h64, 32'h0, '1, 1'b0, "win_cap_wr");
		apb(1'b0, wwd_pkg::REG_WIN_CAP, 32'h0, 32'h64, '1, 1'b0, "win_cap_rd");
		apb(1'b1, wwd_pkg::REG_RST_CAP, 32'h0, 32'h0, '1, 1'b0, "rst_cap_wr");
		apb(1'b0, wwd_pkg::REG_RST_CAP, 32'h0, 32'h0, '1, 1'b0, "rst_cap_rd");
		apb(1'b1, wwd_pkg::REG_STATUS, 32'hff, 32'h0, '1, 1'b1, "status_wr");
		apb(1'b1, wwd_pkg::REG_ELAPSED, 32'hff, 32'h0, '1, 1'b1, "elapsed_wr");
		apb(1'b0, 8'h14, 32'h0, 32'h0, '1, 1'b1, "unmapped");
		// Power-up: checking held off for one reset delay
		supply_ok <= 1'b1;
		repeat (100) @(posedge sys_clk);
		apb(1'b0, wwd_pkg::REG_STATUS, 32'h0, 32'h08, 32'h0f, 1'b0, "st_init");
		i_kick.kick(10, 4);
		repeat (TK * D0) @(posedge sys_clk);
		win_pin <= wwd_pkg::PIN_OPEN;
		dly_pin <= wwd_pkg::PIN_OPEN;
		apb(1'b0, wwd_pkg::REG_STATUS, 32'h0, 32'h64, 32'h6f, 1'b0, "st_first");
		// Early first edge, in-window edge, then too early
		i_kick.kick(100, 4);
		chk("out_first", 32'h1, fault_n);
		i_kick.kick(TK * MID, 4);
		chk("out_window", 32'h1, fault_n);
		i_kick.kick(TK * LWR / 2, 4);
		chk("out_early", 32'h0, fault_n);
		chk("discharge_on", 32'h1, cap_dis);
		i_kick.kick(200, 4);
		repeat (TK * (D0 - 10) - 208) @(posedge sys_clk);
		chk("out_held", 32'h0, fault_n);
		repeat (TK * 20) @(posedge sys_clk);
		chk("out_release", 32'h1, fault_n);
		chk("discharge_off", 32'h0, cap_dis);
		apb(1'b0, wwd_pkg::REG_FAULT_CNT, 32'h0, 32'h1, 32'hffff, 1'b0, "fault_cnt");
		// Missing first edge with a 100 pF delay capacitor
		apb(1'b1, wwd_pkg::REG_RST_CAP, 32'h64, 32'h0, '1, 1'b0, "rst_cap100");
		repeat (TK * UPR - 200) @(posedge sys_clk);
		chk("out_before_up", 32'h1, fault_n);
		repeat (300) @(posedge sys_clk);
		chk("out_late_first", 32'h0, fault_n);
		repeat (TK * (D100 - 15) - 124) @(posedge sys_clk);
		chk("out_held_100", 32'h0, fault_n);
		repeat (60) @(posedge sys_clk);
		chk("out_rel_100", 32'h1, fault_n);
		// Disabled: kicks ignored, output released, timer parked
		sel1 <= 1'b0;
		repeat (3) @(posedge sys_clk);
		for (int i = 0; i < 5; i++) begin
			i_kick.kick(300, 4);
			chk("out_disabled", 32'h1, fault_n);
		end
		apb(1'b0, wwd_pkg::REG_STATUS, 32'h0, 32'h10, 32'h10, 1'b0, "st_dis");
		apb(1'b0, wwd_pkg::REG_ELAPSED, 32'h0, 32'h0, '1, 1'b0, "elapsed_dis");
		// Re-enable; an early rising edge is not a service event
		sel1 <= 1'b1;
		i_kick.kick(100, 1000);
		i_kick.kick(TK * MID - 1000, 4);
		chk("out_rise_ignored", 32'h1, fault_n);
		i_kick.kick(TK * UPR + 200, 4);
		chk("out_late", 32'h0, fault_n);
		// Supply loss in a fault: output released, ratio select sampled again
		supply_ok <= 1'b0;
		repeat (3) @(posedge sys_clk);
		chk("out_unsupplied", 32'h1, fault_n);
		chk("discharge_unsupplied", 32'h0, cap_dis);
		sel0 <= 1'b0;
		supply_ok <= 1'b1;
		apb(1'b0, wwd_pkg::REG_STATUS, 32'h0, 32'h28, 32'h6f, 1'b0, "st_restart");
		final_report();
	end

endmodule : window_watchdog_timer_tb_top
